// ---- hw/ssca_core.sv ----
`timescale 1ns/1ps
// What this block does
// - digital output: (signal - breakpoint) * slope + ordinate
// - slope is 12-bit fixed point: sign, unity bit, ten fraction bits
// - breakpoint is 10-bit unsigned, stored high byte then low byte
// - gap count byte: signal code upper nibble, temperature code lower
// - signal codes F fixed, E one, C two, A three, 8 four, 6 five
// - temperature codes 0 fixed, 5 two, 8 three, B four gaps
// - one byte store holds the signal coefficients; temperature code only sets a gap count
// - active alarm forces programmed level when source passes a limit
// - alarm bytes: low limit, low level, high limit, high level, control
// - alarm bytes compare with upper eight bits of ten-bit measure
// - all five alarm bytes zero means alarm disabled
// - source select is the upper nibble of store byte 31
// - source codes: 2 temp, 6 aux, 0 gain, 3 supply, 4/5 io lines
// - steering drives both io lines from source against three levels
// - steering uses control byte then three transition level bytes
// - alarm and steering never active together
// - byte commands read/write store and read working memory
module ssca_core
(
   input  wire logic                  i_ref_clk,
   input  wire logic                  i_rst,
   input  wire logic                  i_digital_mode,
   input  wire ssca_pkg::ssca_cmd_type i_cmd,
   input  wire logic [9:0]            i_gain_stage_output,
   input  wire logic [9:0]            i_temperature_measure,
   input  wire logic [9:0]            i_aux_analog_input,
   input  wire logic [9:0]            i_supply_monitor_output,
   input  wire logic                  i_first_io_line,
   input  wire logic                  i_second_io_line,
   output logic                       o_first_io_line,
   output logic                       o_first_io_line_oe,
   output logic                       o_second_io_line,
   output logic                       o_second_io_line_oe,
   output logic [9:0]                 o_signal_out,
   output logic                       o_alarm_active,
   output logic [2:0]                 o_signal_gap_count,
   output logic [2:0]                 o_temp_gap_count,
   output logic                       o_rsp_valid,
   output logic [7:0]                 o_rsp_data
);
   // ***********************************************************
   // coefficient store and command port
   // ***********************************************************
   logic [7:0] store_q [ssca_pkg::STORE_DEPTH];
   logic       in_store;
   logic [7:0] ram_byte;
   logic [7:0] rsp_d;
   logic [9:0] corr_q;

   assign in_store = 32'(i_cmd.addr) < ssca_pkg::STORE_DEPTH;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         for (int i = 0; i < ssca_pkg::STORE_DEPTH; i++)
            store_q[i] <= ssca_pkg::STORE_RST;
      end
      else if (i_cmd.valid && i_cmd.write && !i_cmd.ram && in_store)
         store_q[i_cmd.addr] <= i_cmd.wdata;
   end

   // working memory: 10-bit values left justified in two bytes
   assign ram_byte =
      (i_cmd.addr == ssca_pkg::RAM_TEMP_HI) ? i_temperature_measure[9:2] :
      (i_cmd.addr == ssca_pkg::RAM_TEMP_LO) ?
         {i_temperature_measure[1:0], 6'h00} :
      (i_cmd.addr == ssca_pkg::RAM_GAIN_HI) ? i_gain_stage_output[9:2] :
      (i_cmd.addr == ssca_pkg::RAM_GAIN_LO) ?
         {i_gain_stage_output[1:0], 6'h00} :
      (i_cmd.addr == ssca_pkg::RAM_OUT_HI)  ? corr_q[9:2] :
      (i_cmd.addr == ssca_pkg::RAM_OUT_LO)  ? {corr_q[1:0], 6'h00} :
      8'h00;
   assign rsp_d = i_cmd.ram ? ram_byte :
                  in_store  ? store_q[i_cmd.addr] : 8'h00;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_rsp_valid <= 1'b0;
         o_rsp_data  <= 8'h00;
      end
      else
      begin
         o_rsp_valid <= i_cmd.valid && !i_cmd.write;
         o_rsp_data  <= rsp_d;
      end
   end

   // ***********************************************************
   // gap count decode
   // ***********************************************************
   logic [3:0] sig_code;
   logic [3:0] tmp_code;
   logic [2:0] sig_cnt;
   logic [2:0] tmp_cnt;

   assign sig_code = store_q[ssca_pkg::GAP_ADDR][7:4];
   assign tmp_code = store_q[ssca_pkg::GAP_ADDR][3:0];
   // an unknown code falls back to fixed so no stale slope applies
   assign sig_cnt = (sig_code == ssca_pkg::SGAP_1) ? 3'h1 :
                    (sig_code == ssca_pkg::SGAP_2) ? 3'h2 :
                    (sig_code == ssca_pkg::SGAP_3) ? 3'h3 :
                    (sig_code == ssca_pkg::SGAP_4) ? 3'h4 :
                    (sig_code == ssca_pkg::SGAP_5) ? 3'h5 :
                    3'h0;
   assign tmp_cnt = (tmp_code == ssca_pkg::TGAP_2) ? 3'h2 :
                    (tmp_code == ssca_pkg::TGAP_3) ? 3'h3 :
                    (tmp_code == ssca_pkg::TGAP_4) ? 3'h4 :
                    3'h1;

   // ***********************************************************
   // segment table
   // ***********************************************************
   logic [9:0]  seg_bp    [ssca_pkg::NSEG];
   logic [11:0] seg_slope [ssca_pkg::NSEG];
   logic [9:0]  seg_ord   [ssca_pkg::NSEG];
   logic [4:0]  seg_ok;
   logic [2:0]  seg_sel;

   for (genvar g = 0; g < ssca_pkg::NSEG; g++)
   begin : g_seg
      localparam logic [6:0] B =
         ssca_pkg::SEG_BASE + 7'(g * ssca_pkg::SEG_STRIDE);
      assign seg_bp[g] = {store_q[B + ssca_pkg::SEG_BP_HI][1:0],
                          store_q[B + ssca_pkg::SEG_BP_LO]};
      assign seg_slope[g] = {store_q[B + ssca_pkg::SEG_SL_HI][3:0],
                             store_q[B + ssca_pkg::SEG_SL_LO]};
      assign seg_ord[g] = {store_q[B + ssca_pkg::SEG_OR_HI][1:0],
                           store_q[B + ssca_pkg::SEG_OR_LO]};
      // the first segment is the floor, whatever its breakpoint
      assign seg_ok[g] = (g == 0) || ((3'(g) < sig_cnt) &&
                         (seg_bp[g] <= i_gain_stage_output));
   end

   function automatic logic [2:0] top_seg(input logic [4:0] ok);
      logic [2:0] r;
      r = 3'h0;
      for (int i = 0; i < ssca_pkg::NSEG; i++)
         if (ok[i])
            r = 3'(i);
      return r;
   endfunction

   assign seg_sel = top_seg(seg_ok);

   // ***********************************************************
   // correction pipeline
   // ***********************************************************
   logic signed [10:0] diff_q;
   logic signed [11:0] slope_q;
   logic [9:0]         ord_q;
   logic [9:0]         meas_q;
   logic               bypass_q;
   logic [2:0]         sel_q;
   logic signed [22:0] prod;
   logic signed [13:0] sum;
   logic [9:0]         corr_d;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         diff_q   <= 11'sh000;
         slope_q  <= 12'sh000;
         ord_q    <= 10'h000;
         meas_q   <= 10'h000;
         bypass_q <= 1'b1;
         sel_q    <= 3'h0;
      end
      else
      begin
         diff_q   <= $signed({1'b0, i_gain_stage_output}) -
                     $signed({1'b0, seg_bp[seg_sel]});
         slope_q  <= $signed(seg_slope[seg_sel]);
         ord_q    <= seg_ord[seg_sel];
         meas_q   <= i_gain_stage_output;
         bypass_q <= !i_digital_mode || (sig_cnt == 3'h0);
         sel_q    <= seg_sel;
      end
   end

   // full-width product; truncation toward minus infinity is accepted
   assign prod = diff_q * slope_q;
   assign sum  = 14'($signed(prod[22:ssca_pkg::SLOPE_FRAC])) +
                 $signed({4'h0, ord_q});
   assign corr_d = bypass_q     ? meas_q :
                   sum[13]      ? 10'h000 :
                   (|sum[12:10]) ? 10'h3FF : sum[9:0];

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
         corr_q <= 10'h000;
      else
         corr_q <= corr_d;
   end

   // ***********************************************************
   // source select, alarm and level steering
   // ***********************************************************
   logic [1:0] io1_sync_q;
   logic [1:0] io2_sync_q;
   logic [7:0] ctrl;
   logic [9:0] src;
   logic [7:0] src8;
   logic       steer;
   logic       alm_en;
   logic       alm_low;
   logic       alm_high;
   logic [1:0] lvl_cnt;
   logic [9:0] out_d;

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         io1_sync_q <= 2'h0;
         io2_sync_q <= 2'h0;
      end
      else
      begin
         io1_sync_q <= {io1_sync_q[0], i_first_io_line};
         io2_sync_q <= {io2_sync_q[0], i_second_io_line};
      end
   end

   assign ctrl = store_q[ssca_pkg::CTRL_ADDR];
   assign src =
      (ctrl[7:4] == ssca_pkg::SRC_TEMP)   ? i_temperature_measure :
      (ctrl[7:4] == ssca_pkg::SRC_AUX)    ? i_aux_analog_input :
      (ctrl[7:4] == ssca_pkg::SRC_SUPPLY) ? i_supply_monitor_output :
      (ctrl[7:4] == ssca_pkg::SRC_IO1)    ? {10{io1_sync_q[1]}} :
      (ctrl[7:4] == ssca_pkg::SRC_IO2)    ? {10{io2_sync_q[1]}} :
      i_gain_stage_output;
   assign src8  = src[9:2];
   // steering wins: the shared bytes cannot mean both at once
   assign steer = ctrl[ssca_pkg::CTRL_STEER_BIT];
   assign alm_en = !steer && |{store_q[ssca_pkg::ALM_LO_LIM],
                               store_q[ssca_pkg::ALM_LO_OUT],
                               store_q[ssca_pkg::ALM_HI_LIM],
                               store_q[ssca_pkg::ALM_HI_OUT],
                               ctrl};
   assign alm_low  = alm_en &&
                     (src8 < store_q[ssca_pkg::ALM_LO_LIM]);
   assign alm_high = alm_en && !alm_low &&
                     (src8 > store_q[ssca_pkg::ALM_HI_LIM]);
   assign out_d = alm_low  ? {store_q[ssca_pkg::ALM_LO_OUT], 2'h0} :
                  alm_high ? {store_q[ssca_pkg::ALM_HI_OUT], 2'h0} :
                  corr_q;
   assign lvl_cnt =
      2'(src8 >= store_q[ssca_pkg::STEER_LVL1]) +
      2'(src8 >= store_q[ssca_pkg::STEER_LVL2]) +
      2'(src8 >= store_q[ssca_pkg::STEER_LVL3]);

   always_ff @(posedge i_ref_clk)
   begin
      if (i_rst)
      begin
         o_signal_out        <= 10'h000;
         o_alarm_active      <= 1'b0;
         o_first_io_line     <= 1'b0;
         o_second_io_line    <= 1'b0;
         o_first_io_line_oe  <= 1'b0;
         o_second_io_line_oe <= 1'b0;
         o_signal_gap_count  <= 3'h0;
         o_temp_gap_count    <= 3'h1;
      end
      else
      begin
         o_signal_out        <= out_d;
         o_alarm_active      <= alm_low || alm_high;
         o_first_io_line     <= steer && lvl_cnt[0];
         o_second_io_line    <= steer && lvl_cnt[1];
         o_first_io_line_oe  <= steer;
         o_second_io_line_oe <= steer;
         o_signal_gap_count  <= sig_cnt;
         o_temp_gap_count    <= tmp_cnt;
      end
   end

   // ***********************************************************
   // assertions
   // ***********************************************************
   default clocking cb @(posedge i_ref_clk); endclocking
   default disable iff (i_rst);

   sequence s_read_store;
      i_cmd.valid && !i_cmd.write && !i_cmd.ram && in_store;
   endsequence

   a_alarm_low_force:
      assert property (alm_low |=> o_signal_out ==
                       {$past(store_q[ssca_pkg::ALM_LO_OUT]), 2'h0})
      else $error("low alarm level not forced");
   a_alarm_zero_off:
      assert property ((ctrl | store_q[ssca_pkg::ALM_LO_LIM] |
         store_q[ssca_pkg::ALM_LO_OUT] | store_q[ssca_pkg::ALM_HI_LIM] |
         store_q[ssca_pkg::ALM_HI_OUT]) == 8'h00 |=> !o_alarm_active)
      else $error("alarm active while disabled");
   a_steer_no_alarm:
      assert property (steer |=> !o_alarm_active &&
                       o_signal_out == $past(corr_q))
      else $error("alarm acted during steering");
   a_steer_below:
      assert property (steer && src8 < store_q[ssca_pkg::STEER_LVL1] &&
                       src8 < store_q[ssca_pkg::STEER_LVL2] &&
                       src8 < store_q[ssca_pkg::STEER_LVL3]
                       |=> !o_first_io_line && !o_second_io_line &&
                       o_first_io_line_oe)
      else $error("steering lines wrong below all levels");
   a_store_read_back:
      assert property (s_read_store |=> o_rsp_valid &&
                       o_rsp_data == $past(store_q[i_cmd.addr]))
      else $error("store read data mismatch");
   a_write_then_read:
      assert property (i_cmd.valid && i_cmd.write && !i_cmd.ram &&
                       in_store ##1 (s_read_store and
                       i_cmd.addr == $past(i_cmd.addr))
                       |=> o_rsp_data == $past(i_cmd.wdata, 2))
      else $error("written byte not read back");
   a_seg_choice:
      assert property (!i_rst ##1 sel_q != 3'h0 |->
                       $past(seg_bp[seg_sel]) <= meas_q)
      else $error("segment breakpoint above signal");
   a_sig_gap_five:
      assert property (sig_code == ssca_pkg::SGAP_5 |=>
                       o_signal_gap_count == 3'h5)
      else $error("five signal gap decode wrong");
   a_tmp_gap_four:
      assert property (tmp_code == ssca_pkg::TGAP_4 |=>
                       o_temp_gap_count == 3'h4)
      else $error("four temperature gap decode wrong");
   a_bypass_pass:
      assert property (!i_digital_mode ##1 1'b1 |=>
                       corr_q == $past(meas_q))
      else $error("analog mode output not passed through");
endmodule

// ---- hw/ssca_pkg.sv ----
package ssca_pkg;
   // ***********************************************************
   // sizes
   // ***********************************************************
   localparam int STORE_DEPTH = 72;
   localparam int NSEG        = 5;
   localparam int SLOPE_FRAC  = 10;

   // ***********************************************************
   // coefficient store map
   // ***********************************************************
   localparam logic [6:0] GAP_ADDR    = 7'h00;
   localparam logic [6:0] ALM_LO_LIM  = 7'h1B;
   localparam logic [6:0] ALM_LO_OUT  = 7'h1C;
   localparam logic [6:0] ALM_HI_LIM  = 7'h1D;
   localparam logic [6:0] ALM_HI_OUT  = 7'h1E;
   localparam logic [6:0] CTRL_ADDR   = 7'h1F;
   localparam logic [6:0] STEER_LVL1  = 7'h20;
   localparam logic [6:0] STEER_LVL2  = 7'h21;
   localparam logic [6:0] STEER_LVL3  = 7'h22;
   localparam logic [6:0] SEG_BASE    = 7'h24;
   localparam int         SEG_STRIDE  = 6;
   localparam logic [6:0] SEG_BP_HI   = 7'h00;
   localparam logic [6:0] SEG_BP_LO   = 7'h01;
   localparam logic [6:0] SEG_SL_HI   = 7'h02;
   localparam logic [6:0] SEG_SL_LO   = 7'h03;
   localparam logic [6:0] SEG_OR_HI   = 7'h04;
   localparam logic [6:0] SEG_OR_LO   = 7'h05;
   localparam int         CTRL_STEER_BIT = 0;
   localparam logic [7:0] STORE_RST   = 8'h00;

   // ***********************************************************
   // working memory map
   // ***********************************************************
   localparam logic [6:0] RAM_TEMP_HI = 7'h00;
   localparam logic [6:0] RAM_TEMP_LO = 7'h01;
   localparam logic [6:0] RAM_GAIN_HI = 7'h02;
   localparam logic [6:0] RAM_GAIN_LO = 7'h03;
   localparam logic [6:0] RAM_OUT_HI  = 7'h04;
   localparam logic [6:0] RAM_OUT_LO  = 7'h05;

   // ***********************************************************
   // gap count codes
   // ***********************************************************
   localparam logic [3:0] SGAP_FIXED = 4'hF;
   localparam logic [3:0] SGAP_1     = 4'hE;
   localparam logic [3:0] SGAP_2     = 4'hC;
   localparam logic [3:0] SGAP_3     = 4'hA;
   localparam logic [3:0] SGAP_4     = 4'h8;
   localparam logic [3:0] SGAP_5     = 4'h6;
   localparam logic [3:0] TGAP_FIXED = 4'h0;
   localparam logic [3:0] TGAP_2     = 4'h5;
   localparam logic [3:0] TGAP_3     = 4'h8;
   localparam logic [3:0] TGAP_4     = 4'hB;

   // ***********************************************************
   // source select codes
   // ***********************************************************
   localparam logic [3:0] SRC_GAIN   = 4'h0;
   localparam logic [3:0] SRC_TEMP   = 4'h2;
   localparam logic [3:0] SRC_SUPPLY = 4'h3;
   localparam logic [3:0] SRC_IO1    = 4'h4;
   localparam logic [3:0] SRC_IO2    = 4'h5;
   localparam logic [3:0] SRC_AUX    = 4'h6;

   typedef struct packed {
      logic       valid;
      logic       write;
      logic       ram;
      logic [6:0] addr;
      logic [7:0] wdata;
   } ssca_cmd_type;
endpackage

// ---- verif/ssca_front_end.sv ----
`timescale 1ns/1ps
// ***********************************************************
// sensor front end: four converter outputs and two io pins
// ***********************************************************
module ssca_front_end
(
   input  wire logic [2:0] i_hot_sel,
   input  wire logic [9:0] i_hot_lvl,
   input  wire logic [9:0] i_base_lvl,
   input  wire logic       i_first_out,
   input  wire logic       i_first_oe,
   input  wire logic       i_second_out,
   input  wire logic       i_second_oe,
   output logic [9:0]      o_gain,
   output logic [9:0]      o_temp,
   output logic [9:0]      o_supply,
   output logic [9:0]      o_aux,
   output logic            o_first_pin,
   output logic            o_second_pin
);
   // one source at a time is pushed away from the common level
   assign o_gain   = (i_hot_sel == 3'h0) ? i_hot_lvl : i_base_lvl;
   assign o_temp   = (i_hot_sel == 3'h1) ? i_hot_lvl : i_base_lvl;
   assign o_supply = (i_hot_sel == 3'h2) ? i_hot_lvl : i_base_lvl;
   assign o_aux    = (i_hot_sel == 3'h5) ? i_hot_lvl : i_base_lvl;
   // the front end yields a pin while the block drives it
   assign o_first_pin  = i_first_oe  ? i_first_out  : (i_hot_sel == 3'h3);
   assign o_second_pin = i_second_oe ? i_second_out : (i_hot_sel == 3'h4);
endmodule

// ---- verif/tb_top.sv ----
`timescale 1ns/1ps
module tb_top;
   // ***********************************************************
   // wiring
   // ***********************************************************
   logic                   i_ref_clk      = 1'b0;
   logic                   i_rst          = 1'b1;
   logic                   i_digital_mode = 1'b1;
   ssca_pkg::ssca_cmd_type i_cmd          = '0;
   logic [2:0]             hot_sel        = 3'h0;
   logic [9:0]             hot_lvl        = 10'h200;
   logic [9:0]             gain, temp, supply, aux, sig_out;
   logic                   pin1, pin2, io1, io1_oe, io2, io2_oe;
   logic                   alarm, rsp_valid;
   logic [2:0]             sgap, tgap;
   logic [7:0]             rsp_data;
   int                     errors          = 0;
   int                     samples_checked = 0;
   logic [3:0]             scode [6] = '{4'hF, 4'hE, 4'hC, 4'hA, 4'h8, 4'h6};
   logic [3:0]             tcode [4] = '{4'h0, 4'h5, 4'h8, 4'hB};
   logic [3:0]             src   [6] = '{4'h0, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6};
   logic [9:0]             c_in  [4] = '{10'h100, 10'h1FF, 10'h200, 10'h280};
   logic [9:0]             c_exp [4] = '{10'h110, 10'h20F, 10'h300, 10'h2C0};
   logic [9:0]             s_in  [4] = '{10'h080, 10'h100, 10'h200, 10'h3FC};

   always #25 i_ref_clk = ~i_ref_clk;

   ssca_front_end u_fe (.i_hot_sel(hot_sel), .i_hot_lvl(hot_lvl),
      .i_base_lvl(10'h200), .i_first_out(io1), .i_first_oe(io1_oe),
      .i_second_out(io2), .i_second_oe(io2_oe), .o_gain(gain),
      .o_temp(temp), .o_supply(supply), .o_aux(aux),
      .o_first_pin(pin1), .o_second_pin(pin2));

   ssca_core u_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst),
      .i_digital_mode(i_digital_mode), .i_cmd(i_cmd),
      .i_gain_stage_output(gain), .i_temperature_measure(temp),
      .i_aux_analog_input(aux), .i_supply_monitor_output(supply),
      .i_first_io_line(pin1), .i_second_io_line(pin2),
      .o_first_io_line(io1), .o_first_io_line_oe(io1_oe),
      .o_second_io_line(io2), .o_second_io_line_oe(io2_oe),
      .o_signal_out(sig_out), .o_alarm_active(alarm),
      .o_signal_gap_count(sgap), .o_temp_gap_count(tgap),
      .o_rsp_valid(rsp_valid), .o_rsp_data(rsp_data));

   // ***********************************************************
   // tasks
   // ***********************************************************
   task automatic check(input string what, input logic [9:0] seen,
                        input logic [9:0] exp);
      samples_checked++;
      if (seen !== exp)
      begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", what, exp, seen);
      end
   endtask

   task automatic results();
      if (errors == 0 && samples_checked > 0)
         $display("bench passed");
      else
         $display("bench failed");
      $finish;
   endtask

   // valid drops for one edge between writes, so each is a clean pulse
   task automatic wr(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_cmd <= '{1'b1, 1'b1, 1'b0, a, d};
      @(posedge i_ref_clk);
      i_cmd <= '0;
   endtask

   // answer lands on the taking edge, one cycle after the command is driven
   task automatic rdchk(input string what, input logic ram,
                        input logic [6:0] a, input logic [7:0] exp);
      @(posedge i_ref_clk);
      i_cmd <= '{1'b1, 1'b0, ram, a, 8'h00};
      @(posedge i_ref_clk);
      i_cmd <= '0;
      #1;
      check("read answer", {9'h000, rsp_valid}, 10'h001);
      check(what, {2'h0, rsp_data}, {2'h0, exp});
   endtask

   // write then read the same byte on the very next edge
   task automatic wrrd(input logic [6:0] a, input logic [7:0] d);
      @(posedge i_ref_clk);
      i_cmd <= '{1'b1, 1'b1, 1'b0, a, d};
      @(posedge i_ref_clk);
      i_cmd <= '{1'b1, 1'b0, 1'b0, a, 8'h00};
      @(posedge i_ref_clk);
      i_cmd <= '0;
      #1;
      check("back to back read", {1'b0, rsp_valid, rsp_data},
            {2'h1, d});
   endtask

   // covers input stage, sync flops and the output register
   task automatic settle();
      repeat (8) @(posedge i_ref_clk);
      #1;
   endtask

   task automatic seg(input int k, input logic [9:0] bp,
                      input logic [11:0] sl, input logic [9:0] od);
      logic [6:0] b;
      b = 7'(36 + 6 * k);
      wr(b, {6'h00, bp[9:8]});
      wr(b + 7'h01, bp[7:0]);
      wr(b + 7'h02, {4'h0, sl[11:8]});
      wr(b + 7'h03, sl[7:0]);
      wr(b + 7'h04, {6'h00, od[9:8]});
      wr(b + 7'h05, od[7:0]);
   endtask

   // ***********************************************************
   // main sequence
   // ***********************************************************
   initial
   begin
      repeat (20000) @(posedge i_ref_clk);
      errors++;
      results();
   end

   initial
   begin
      repeat (8) @(posedge i_ref_clk);
      i_rst <= 1'b0;
      #1;
      check("temp gaps at reset", {7'h00, tgap}, 10'h001);
      check("io enables reset", {8'h00, io1_oe, io2_oe}, 10'h000);
      hot_lvl <= 10'h3FC;
      settle();
      check("alarm with zero bytes", {9'h000, alarm}, 10'h000);
      check("fixed signal bypass", sig_out, 10'h3FC);
      wr(7'h05, 8'hA5);
      rdchk("store readback", 1'b0, 7'h05, 8'hA5);
      wr(7'h48, 8'h77);
      rdchk("store beyond end", 1'b0, 7'h48, 8'h00);
      wrrd(7'h06, 8'h5A);
      hot_sel <= 3'h1;
      hot_lvl <= 10'h2B7;
      settle();
      rdchk("temperature high", 1'b1, 7'h00, 8'hAD);
      rdchk("temperature low", 1'b1, 7'h01, 8'hC0);
      for (int k = 0; k < 6; k++)
      begin
         wr(7'h00, {scode[k], 4'h0});
         settle();
         check("signal gaps", {7'h00, sgap}, 10'(k));
      end
      for (int k = 0; k < 4; k++)
      begin
         wr(7'h00, {4'hF, tcode[k]});
         settle();
         check("temp gaps", {7'h00, tgap}, 10'(k + 1));
      end
      // segment two sits below segment one but lies past the count
      seg(0, 10'h000, 12'h400, 10'h010);
      seg(1, 10'h200, 12'hE00, 10'h300);
      seg(2, 10'h100, 12'h400, 10'h3FF);
      wr(7'h00, 8'hC0);
      hot_sel <= 3'h0;
      for (int k = 0; k < 4; k++)
      begin
         hot_lvl <= c_in[k];
         settle();
         check("corrected", sig_out, c_exp[k]);
      end
      i_digital_mode <= 1'b0;
      settle();
      check("pass through", sig_out, 10'h280);
      rdchk("gain high", 1'b1, 7'h02, 8'hA0);
      rdchk("output high", 1'b1, 7'h04, 8'hA0);
      i_digital_mode <= 1'b1;
      wr(7'h1B, 8'h40);
      wr(7'h1C, 8'h11);
      wr(7'h1D, 8'hC0);
      wr(7'h1E, 8'hEE);
      hot_lvl <= 10'h3FC;
      for (int k = 0; k < 6; k++)
      begin
         hot_sel <= 3'(k);
         wr(7'h1F, {src[k], 4'h0});
         settle();
         check("high clamp", sig_out, 10'h3B8);
         check("high active", {9'h000, alarm}, 10'h001);
      end
      hot_sel <= 3'h0;
      wr(7'h1F, 8'h00);
      hot_lvl <= 10'h004;
      settle();
      check("low clamp", sig_out, 10'h044);
      hot_lvl <= 10'h300;
      settle();
      check("at high limit", {9'h000, alarm}, 10'h000);
      check("at high limit out", sig_out, 10'h280);
      wr(7'h20, 8'h40);
      wr(7'h21, 8'h80);
      wr(7'h22, 8'hC0);
      wr(7'h1F, 8'h01);
      for (int k = 0; k < 4; k++)
      begin
         hot_lvl <= s_in[k];
         settle();
         check("steer lines", {8'h00, io2, io1}, 10'(k));
         check("steer enables", {8'h00, io1_oe, io2_oe}, 10'h003);
         check("no alarm steering", {9'h000, alarm}, 10'h000);
      end
      results();
   end
endmodule
